/* File: design/std_timer_regs.svh */
// Purpose: named constants for the standard timer mode logic
// Assumes: 16-bit counter, 8-bit period compare on the upper byte
// Notes:   included by the timer design files
`ifndef STD_TIMER_REGS_SVH
`define STD_TIMER_REGS_SVH

`define MODE_COMPARE     2'h0
`define MODE_CAPTURE     2'h1
`define MODE_PWM         2'h2
`define MODE_TIMER       2'h3
`define ACT_NONE         2'h0
`define ACT_LOW          2'h1
`define ACT_HIGH         2'h2
`define ACT_TOGGLE       2'h3
`define CNT_ZERO         16'h0000
`define CNT_ONE          16'h0001
`define CNT_ONE_X        17'h00001
`define PERIOD_ZERO      8'h00
`define SYNC_ZERO        2'h0

`endif

/* File: design/std_timer_pkg.sv */
// Purpose: shared types for the standard timer mode logic
// Assumes: nothing
// Notes:   none
package std_timer_pkg;

	typedef enum logic [1:0]
	{
		OP_COMPARE,
		OP_TIMER,
		OP_PWM,
		OP_PULSE
	} op_mode_e;

	typedef struct packed
	{
		logic [1:0] modeSel;
		logic [1:0] outAction;
		logic       clearSelect;
		logic       outInitialLevel;
		logic       dutyPeriodSwap;
	} timer_ctrl_s;

	typedef struct packed
	{
		logic matchAFlag;
		logic matchPFlag;
	} timer_flags_s;

endpackage : std_timer_pkg

/* File: design/edge_sync.sv */
// Purpose: two-stage synchroniser with rising-edge pulse
// Assumes: asynchronous input level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module edge_sync
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Level in, edge out
	input  wire logic asyncIn,
	output logic      riseOut
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end
		else
		begin
			meta_q <= asyncIn;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign riseOut = sync_q & ~last_q;
endmodule : edge_sync

/* File: design/standard_timer.sv */
// Purpose: operating-mode logic of a 16-bit standard timer
// Assumes: clk is the selected timer clock; control bits from same domain
// Notes:   capture mode is not served; counter holds while stopped
//
// Behaviour
// (RULE1) Mode-select 00 gives compare-match output mode.
// (RULE2) Mode-select 11 works as compare mode but leaves the pin unused.
// (RULE3) Mode-select 10 with output action 10 gives PWM mode.
// (RULE4) Mode-select 10 with output action 11 gives single-pulse mode.
// (RULE5) Clear-select low: clear on P match or wrap; A and P flags raised.
// (RULE6) Clear-select high: clear on A match; only the A flag is raised.
// (RULE7) Software must not load A with zero in compare mode.
// (RULE8) In compare mode only an A match changes the pin.
// (RULE9) Output action picks high, low or toggle; 00 leaves the pin.
// (RULE10) Initial-level bit sets the pin; run rising edge restores it, except in pulse mode.
// (RULE11) PWM ignores clear-select; swap bit picks period and duty register.
// (RULE12) Swap 0: period is P times 256, or 65536 at zero; duty is A.
// (RULE13) Duty at or above period keeps PWM output active all period.
// (RULE14) Swap 1: period is A; duty is P times 256, or 65536 at zero.
// (RULE15) PWM counting keeps running with output action 00 or 01.
// (RULE16) Pulse mode: run rising edge starts count; trigger edge sets run.
// (RULE17) Pulse ends on software clear or A match, which raises interrupt.
// (RULE18) Pulse mode zeroes counter only on run rising edge; P ignored.
// (RULE19) P matches the counter's upper eight bits with the lower eight zero; P of zero matches at all ones.
// (RULE20) Counter advances only while run is high, else holds.
`timescale 1ns/1ns
`include "std_timer_regs.svh"
module standard_timer
#(
	parameter int CNT_W = 16,
	parameter int PER_W = 8
)
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// Control bits from software
	input  wire std_timer_pkg::timer_ctrl_s ctrl,
	input  wire logic                 runSet,
	input  wire logic                 runClear,
	input  wire logic [CNT_W-1:0]     compareAValue,
	input  wire logic [PER_W-1:0]     comparePValue,
	input  wire logic                 matchAFlagClear,
	input  wire logic                 matchPFlagClear,
	// External trigger pin
	input  wire logic                 extTriggerPin,
	// Status to software
	output logic                      counterRun,
	output logic [CNT_W-1:0]          count,
	output std_timer_pkg::timer_flags_s flags,
	// Timer output pin
	output logic                      timerOut,
	output logic                      timerOutEn
);
	// ==========================================================
	// Parameter checks
	// ==========================================================
	initial
	begin
		if (CNT_W != 16 || PER_W != 8)
		begin
			$error("standard_timer supports only a 16-bit counter, 8-bit period");
		end
	end

	// ==========================================================
	// Helpers
	// ==========================================================
	function automatic logic periodHit(input logic [CNT_W-1:0] c,
		input logic [PER_W-1:0] p);
		logic [PER_W-1:0] top;
		top = c[CNT_W-1:CNT_W-PER_W];
		if (p == `PERIOD_ZERO)
			periodHit = (c == {CNT_W{1'b1}});
		else
			periodHit = (top == p) && (c[CNT_W-PER_W-1:0] == '0);
	endfunction : periodHit

	// Period or duty threshold from P: P x 256, or 65536 at zero, in 17 bits
	function automatic logic [CNT_W:0] pScaled(input logic [PER_W-1:0] p);
		if (p == `PERIOD_ZERO)
			pScaled = {1'b1, {CNT_W{1'b0}}};
		else
			pScaled = {1'b0, p, {(CNT_W-PER_W){1'b0}}};
	endfunction : pScaled

	// ==========================================================
	// Mode decode
	// ==========================================================
	std_timer_pkg::op_mode_e opMode;
	logic                    modeValid;

	always_comb
	begin
		opMode    = std_timer_pkg::OP_COMPARE;
		modeValid = 1'b1;
		unique case (ctrl.modeSel)
			`MODE_COMPARE: opMode = std_timer_pkg::OP_COMPARE; // RULE1
			`MODE_TIMER:   opMode = std_timer_pkg::OP_TIMER; // RULE2
			`MODE_PWM:
			begin
				if (ctrl.outAction == `ACT_TOGGLE)
					opMode = std_timer_pkg::OP_PULSE; // RULE4
				else
					opMode = std_timer_pkg::OP_PWM; // RULE3 RULE15
			end
			`MODE_CAPTURE: modeValid = 1'b0;
		endcase
	end

	logic isCompare;
	logic isPwm;
	logic isPulse;
	assign isCompare = modeValid && (opMode == std_timer_pkg::OP_COMPARE
		|| opMode == std_timer_pkg::OP_TIMER);
	assign isPwm   = modeValid && opMode == std_timer_pkg::OP_PWM;
	assign isPulse = modeValid && opMode == std_timer_pkg::OP_PULSE;

	// ==========================================================
	// Trigger pin synchroniser
	// ==========================================================
	logic trigRise;

	edge_sync u_trig
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.asyncIn (extTriggerPin),
		.riseOut (trigRise)
	);

	// ==========================================================
	// Comparators
	// ==========================================================
	logic [CNT_W-1:0] cnt_q;
	logic             matchA;
	logic             matchP;

	assign matchA = counterRun && cnt_q == compareAValue;
	assign matchP = counterRun && periodHit(cnt_q, comparePValue); // RULE19

	// PWM compares one count early so a period of N spans exactly N clocks
	logic pwmAHit;
	logic pwmPHit;

	assign pwmAHit = counterRun
		&& ({1'b0, cnt_q} == ({1'b0, compareAValue} - `CNT_ONE_X)); // RULE14
	assign pwmPHit = counterRun
		&& ({1'b0, cnt_q} == (pScaled(comparePValue) - `CNT_ONE_X)); // RULE12

	// ==========================================================
	// Run bit
	// ==========================================================
	logic run_q;
	logic runPrev_q;
	logic runRise;

	assign runRise = run_q & ~runPrev_q;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			run_q <= 1'b0;
		else if (runSet || (isPulse && trigRise)) // RULE16
			run_q <= 1'b1;
		else if (runClear || (isPulse && matchA)) // RULE17
			run_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			runPrev_q <= 1'b0;
		else
			runPrev_q <= run_q;
	end

	// ==========================================================
	// Counter clear selection
	// ==========================================================
	logic clearCnt;

	always_comb
	begin
		clearCnt = 1'b0;
		if (isCompare)
			clearCnt = ctrl.clearSelect ? matchA : matchP; // RULE5 RULE6
		else if (isPwm)
			clearCnt = ctrl.dutyPeriodSwap ? pwmAHit : pwmPHit; // RULE11
		else if (!modeValid)
			clearCnt = matchP;
	end

	// ==========================================================
	// Counter
	// ==========================================================
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cnt_q <= `CNT_ZERO;
		else if (runRise)
			cnt_q <= `CNT_ZERO; // RULE18
		else if (run_q)
		begin
			if (clearCnt && !isPulse)
				cnt_q <= `CNT_ZERO;
			else
				cnt_q <= cnt_q + `CNT_ONE; // RULE20
		end
	end

	// ==========================================================
	// Match flags (set wins over clear)
	// ==========================================================
	logic setA;
	logic setP;
	logic flagA_q;
	logic flagP_q;

	assign setA = (matchA && (isCompare || isPulse)) || (isPwm && pwmAHit); // RULE17
	assign setP = (matchP && isCompare && !ctrl.clearSelect)
		|| (isPwm && pwmPHit); // RULE5 RULE6

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			flagA_q <= 1'b0;
		else if (setA)
			flagA_q <= 1'b1;
		else if (matchAFlagClear)
			flagA_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			flagP_q <= 1'b0;
		else if (setP)
			flagP_q <= 1'b1;
		else if (matchPFlagClear)
			flagP_q <= 1'b0;
	end

	// ==========================================================
	// PWM duty
	// ==========================================================
	logic [CNT_W:0] dutyVal;
	logic [CNT_W:0] periodVal;
	logic           pwmActive;

	always_comb
	begin
		if (ctrl.dutyPeriodSwap)
		begin
			dutyVal   = pScaled(comparePValue); // RULE14
			periodVal = {1'b0, compareAValue};
		end
		else
		begin
			dutyVal   = {1'b0, compareAValue}; // RULE12
			periodVal = pScaled(comparePValue);
		end
		pwmActive = (dutyVal >= periodVal) // RULE13
			|| ({1'b0, cnt_q} < dutyVal);
	end

	// ==========================================================
	// Output pin
	// ==========================================================
	logic out_q;
	logic outNext;

	always_comb
	begin
		outNext = out_q;
		unique case (ctrl.outAction) // RULE9
			`ACT_NONE:   outNext = out_q;
			`ACT_LOW:    outNext = 1'b0;
			`ACT_HIGH:   outNext = 1'b1;
			`ACT_TOGGLE: outNext = ~out_q;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			out_q <= 1'b0;
		else if (!run_q || runRise)
		begin
			if (isPulse && runRise)
				out_q <= ~ctrl.outInitialLevel; // RULE16
			else if (!isPulse || runRise)
				out_q <= ctrl.outInitialLevel; // RULE10
			else
				out_q <= ctrl.outInitialLevel; // RULE17
		end
		else if (isCompare && setA)
			out_q <= outNext; // RULE8
		else if (isPwm)
			out_q <= pwmActive ? ~ctrl.outInitialLevel
				: ctrl.outInitialLevel; // RULE13
		else if (isPulse && matchA)
			out_q <= ctrl.outInitialLevel; // RULE17
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign counterRun = run_q;
	assign count      = cnt_q;
	assign flags      = '{matchAFlag: flagA_q, matchPFlag: flagP_q};
	assign timerOut   = out_q;
	assign timerOutEn = modeValid && opMode != std_timer_pkg::OP_TIMER; // RULE2
endmodule : standard_timer

/* File: bench/standard_timer_properties.sv */
// Purpose: port checks of the standard timer
// Assumes: ctrl held steady while running
// Notes:   bound to the design below
`timescale 1ns/1ns
module standard_timer_properties
#(
	parameter int CNT_W = 16,
	parameter int PER_W = 8
)
(
	// Clock and reset
	input wire logic	clk,
	input wire logic	sys_rst,
	// Design inputs
	input wire std_timer_pkg::timer_ctrl_s	ctrl,
	input wire logic	runSet,
	input wire logic [CNT_W-1:0]	compareAValue,
	input wire logic [PER_W-1:0]	comparePValue,
	// Design outputs
	input wire logic	counterRun,
	input wire logic [CNT_W-1:0]	count,
	input wire std_timer_pkg::timer_flags_s	flags,
	input wire logic	timerOut,
	input wire logic	timerOutEn
);
	// ========
	// Helpers
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	wire	cmp = ctrl.modeSel == 2'h0;
	wire	pHit = comparePValue == '0 ? &count : count == {comparePValue, 8'h00};
	sequence s_aHit;
		ctrl.modeSel == 2'h2 && ctrl.outAction == 2'h3 && counterRun && !runSet
			&& $past(counterRun) && count == compareAValue;
	endsequence
	sequence s_pulseEnd;
		!counterRun && timerOut == ctrl.outInitialLevel && flags.matchAFlag;
	endsequence
	// ========
	// Properties
	property p_run;
		runSet |=> counterRun;
	endproperty
	a_run: assert property (p_run) else $error("run bit not set");
	property p_hold;
		!counterRun |=> $stable(count);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved while stopped");
	property p_zero;
		$rose(counterRun) |=> count == '0;
	endproperty
	a_zero: assert property (p_zero) else $error("count not zeroed at start");
	property p_pOnly;
		cmp && ctrl.clearSelect && !flags.matchPFlag |=> !flags.matchPFlag;
	endproperty
	a_pOnly: assert property (p_pOnly) else $error("P flag with A clear");
	property p_pSet;
		cmp && !ctrl.clearSelect && counterRun && $past(counterRun) && pHit |=> flags.matchPFlag;
	endproperty
	a_pSet: assert property (p_pSet) else $error("P flag missing");
	property p_oen;
		timerOutEn == (ctrl.modeSel == 2'h0 || ctrl.modeSel == 2'h2);
	endproperty
	a_oen: assert property (p_oen) else $error("pin enable wrong");
	property p_pulse;
		s_aHit |=> s_pulseEnd;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse did not end");
	property p_pin;
		cmp && $past(ctrl.modeSel) == 2'h0 && counterRun && $past(counterRun)
			&& !flags.matchAFlag |-> $stable(timerOut);
	endproperty
	a_pin: assert property (p_pin) else $error("pin moved without A flag");
endmodule : standard_timer_properties

bind standard_timer standard_timer_properties #(.CNT_W(CNT_W), .PER_W(PER_W)) u_props
(
	.clk(clk), .sys_rst(sys_rst), .ctrl(ctrl), .runSet(runSet),
	.compareAValue(compareAValue), .comparePValue(comparePValue),
	.counterRun(counterRun), .count(count), .flags(flags),
	.timerOut(timerOut), .timerOutEn(timerOutEn)
);

/* File: bench/trigger_source.sv */
// Purpose: external source driving the trigger pin
// Assumes: fire is a bench pulse
// Notes:   edge lands between timer clock edges
`timescale 1ns/1ns
module trigger_source
(
	// Clock and request
	input wire logic	clk,
	input wire logic	fire,
	// Pin
	output logic	extTriggerPin
);
	initial extTriggerPin = 1'b0;
	// Held long enough for the synchroniser to see it
	always @(posedge fire)
	begin
		#3 extTriggerPin = 1'b1;
		repeat (6) @(posedge clk);
		#1 extTriggerPin = 1'b0;
	end
endmodule : trigger_source

/* File: bench/standard_timer_tb_top.sv */
// Purpose: self-checking bench for the standard timer
// Assumes: trigger_source drives the trigger pin
// Notes:   expectations come from the models below
`timescale 1ns/1ns
module standard_timer_tb_top;
	// ========
	// Signals
	logic	clk, sys_rst, runSet, runClear, aClr, pClr, fire, trig;
	logic	run, tOut, tOutEn, init;
	logic [15:0]	aVal, count;
	logic [7:0]	pVal;
	std_timer_pkg::timer_ctrl_s	ctrl;
	std_timer_pkg::timer_flags_s	flags;
	int	fails = 0;
	int	num_checks = 0;
	int	cyc = 0;
	int	a, n, per, duty, hi;
	standard_timer u_standard_timer
	(
		.clk(clk), .sys_rst(sys_rst), .ctrl(ctrl), .runSet(runSet), .runClear(runClear),
		.compareAValue(aVal), .comparePValue(pVal), .matchAFlagClear(aClr),
		.matchPFlagClear(pClr), .extTriggerPin(trig), .counterRun(run), .count(count),
		.flags(flags), .timerOut(tOut), .timerOutEn(tOutEn)
	);
	trigger_source u_trigger_source (.clk(clk), .fire(fire), .extTriggerPin(trig));
	// ========
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask : tick
	task automatic setCtrl(input logic [1:0] m, act, input logic cs, i, sw);
		@(negedge clk);
		{runClear, aClr, pClr} = 3'h7;
		ctrl = '{m, act, cs, i, sw};
		@(negedge clk);
		{runClear, aClr, pClr} = 3'h0;
	endtask : setCtrl
	task automatic start();
		@(negedge clk);
		runSet = 1'b1;
		@(negedge clk);
		runSet = 1'b0;
	endtask : start
	function automatic logic cond(input int k);
		case (k)
			0: return flags.matchAFlag;
			1: return flags.matchPFlag;
			2: return run;
			default: return !run;
		endcase
	endfunction : cond
	task automatic waitUntil(input int k, output int m);
		m = 0;
		while (cond(k) !== 1'b1 && m < 2000)
		begin
			@(negedge clk);
			m++;
		end
	endtask : waitUntil
	function automatic logic expPin(input int k, input logic i);
		case (k)
			0: return i;
			1: return 1'b0;
			2: return 1'b1;
			default: return !i;
		endcase
	endfunction : expPin
	// ========
	// Clock, timeout, sequence
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			fails++;
			report_and_stop();
		end
	end
	initial
	begin
		{sys_rst, runSet, runClear, aClr, pClr, fire} = 6'h20;
		ctrl = '0;
		aVal = 16'h0001;
		pVal = 8'h00;
		void'($urandom(32'h3f090e0b));
		tick(5);
		sys_rst = 1'b0;
		chk({run, flags, tOut, count}, 0);
		for (int m = 0; m < 4; m++)
		begin
			setCtrl(m[1:0], 2'h0, 1'b0, 1'b0, 1'b0);
			chk(tOutEn, m == 0 || m == 2);
		end
		for (int k = 0; k < 5; k++)
		begin
			a = $urandom_range(60, 20);
			init = 1'($urandom_range(1, 0));
			aVal = a[15:0];
			setCtrl(k == 4 ? 2'h3 : 2'h0, k[1:0], 1'b1, init, 1'b0);
			start();
			tick(1);
			chk(tOut, init);
			waitUntil(0, n);
			chk(n, a + 1);
			if (k < 4)
				chk(tOut, expPin(k, init));
			chk(flags.matchPFlag, 0);
		end
		aVal = 16'd100;
		pVal = 8'h01;
		setCtrl(2'h0, 2'h3, 1'b0, 1'b0, 1'b0);
		start();
		waitUntil(1, n);
		chk(n, 258);
		chk({flags.matchAFlag, tOut}, 2'h3);
		setCtrl(2'h0, 2'h3, 1'b0, 1'b0, 1'b0);
		a = count;
		tick(5);
		chk(count, a);
		for (int k = 0; k < 3; k++)
		begin
			a = k == 0 ? 64 : k == 1 ? 300 : 400;
			aVal = a[15:0];
			init = 1'($urandom_range(1, 0));
			setCtrl(2'h2, 2'h2, 1'($urandom_range(1, 0)), init, k == 2);
			start();
			tick(20);
			per = k == 2 ? a : 256;
			duty = k == 2 ? 256 : a;
			hi = 0;
			repeat (2 * per)
			begin
				@(negedge clk);
				if (tOut === !init)
					hi++;
			end
			chk(hi, 2 * (duty < per ? duty : per));
		end
		setCtrl(2'h2, 2'h1, 1'b0, 1'b0, 1'b0);
		start();
		waitUntil(1, n);
		chk(n, 257);
		aVal = 16'd50;
		setCtrl(2'h2, 2'h3, 1'b1, 1'b0, 1'b1);
		fire = 1'b1;
		tick(1);
		fire = 1'b0;
		waitUntil(2, n);
		tick(1);
		chk(tOut, 1);
		waitUntil(3, n);
		chk(n, 51);
		chk({tOut, flags.matchAFlag}, 2'h1);
		start();
		tick(10);
		chk(tOut, 1);
		runClear = 1'b1;
		tick(1);
		runClear = 1'b0;
		tick(1);
		chk({run, tOut}, 0);
		report_and_stop();
	end
endmodule : standard_timer_tb_top
